// File: grb_pkg.sv
/*
 * Shared constants and carrier types for the gyro rate readout and bias command block.
 * Assumes a single 10 MHz clock domain and a synchronous active-high reset.
 */
package grb_pkg;
	localparam int RATE_W = 16;
	localparam int CMD_CTRL_W = 19;
	localparam int BIAS_W = 10;
	localparam int BIAS_ADDR_W = 3;
	localparam int CMD_W = CMD_CTRL_W + BIAS_W + BIAS_ADDR_W;
	localparam int STATUS_W = 32;
	localparam int BIAS_REGS = 3;
	// Command word field positions, first bit received ends up in the MSB
	localparam int CMD_CTRL_LSB = 0;
	localparam int CMD_BIAS_LSB = CMD_CTRL_LSB + CMD_CTRL_W;
	localparam int CMD_ADDR_LSB = CMD_BIAS_LSB + BIAS_W;
	localparam logic [15:0] RATE_RST = 16'h0000;
	localparam logic [9:0] BIAS_RST = 10'h000;
	localparam logic [18:0] CTRL_RST = 19'h0_0000;

	typedef struct packed {
		logic [BIAS_ADDR_W-1:0] bias_addr;
		logic [BIAS_W-1:0] bias_val;
		logic [CMD_CTRL_W-1:0] ctrl;
	} grb_cmd_s;

	typedef struct packed {
		logic envelope;
		logic transfer;
		logic shift_clk;
	} grb_tlm_s;
endpackage

// File: grb_top.sv
/*
 * Gyro channel rate counter with telemetry shift-out, plus the control unit command
 * decoder, bias registers and 32-bit status word serialiser.
 * Assumes pins from the telemetry collectors, command decoders and quantizer are
 * asynchronous and are synchronised here; the housekeeping word is from clock logic.
 */
`timescale 1ns/1ps
// Behaviour
// - Normal-channel quantized pulses are accumulated in a 16-bit signed up/down counter.
// - Only the normal quantizer feeds the counter while the selected quantizer drives the torquer.
// - A 16-bit shift register holds the rate and is loaded and shifted by collector controls.
// - One of two command decoder inputs is chosen and its serial word made parallel.
// - The parallel word splits into 19 control bits, a 10-bit bias and a 3-bit address.
// - The bias value is written into whichever of three 10-bit bias registers the address picks.
// - A 32-bit status word of error streams and housekeeping is shifted to both collectors.
module grb_top (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic norm_up_in,
	input wire logic norm_dn_in,
	input wire logic test_up_in,
	input wire logic test_dn_in,
	input wire logic test_sel_in,
	input wire grb_pkg::grb_tlm_s tlm_a_in,
	input wire grb_pkg::grb_tlm_s tlm_b_in,
	input wire logic cmd_sel_in,
	input wire logic [1:0] cmd_data_in,
	input wire logic [1:0] cmd_clk_in,
	input wire logic [1:0] cmd_env_in,
	input wire logic [5:0] err_bits_in,
	input wire logic [25:0] hk_in,
	output logic torq_up_out,
	output logic torq_dn_out,
	output logic [1:0] rate_ser_out,
	output logic [1:0] status_ser_out,
	output logic [18:0] ctrl_bits_out,
	output logic [29:0] bias_out,
	output logic cmd_done_out
);
	localparam int SYN = 17;

	// Elaboration-time guards on the shared widths
	if (grb_pkg::CMD_W > 63) begin : g_cmd_too_wide
		$error("command word too wide for the bit counter");
	end
	if (grb_pkg::BIAS_REGS * grb_pkg::BIAS_W != 30) begin : g_bias_mismatch
		$error("bias registers do not fill the bias port");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [SYN-1:0] raw;
	logic [SYN-1:0] s1_r;
	logic [SYN-1:0] s2_r;
	logic [SYN-1:0] s3_r;
	// Synchroniser bit map, top down:
	// 16:15 command envelopes, 14:13 normal up and down, 12:11 test up and down,
	// 10 test select, 9:7 collector A controls, 6:4 collector B controls,
	// 3:2 command data, 1:0 command bit clocks
	assign raw = {cmd_env_in, norm_up_in, norm_dn_in, test_up_in, test_dn_in, test_sel_in,
		tlm_a_in, tlm_b_in, cmd_data_in, cmd_clk_in};
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else if (clk_en_in) begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	logic n_up;
	logic n_dn;
	logic t_up;
	logic t_dn;
	logic t_sel;
	assign n_up = rise(s2_r[14], s3_r[14]);
	assign n_dn = rise(s2_r[13], s3_r[13]);
	assign t_up = s2_r[12];
	assign t_dn = s2_r[11];
	assign t_sel = s2_r[10];

	// ****************************************
	// Torquer drive and rate counter
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			torq_up_out <= 1'b0;
			torq_dn_out <= 1'b0;
		end else if (clk_en_in) begin
			torq_up_out <= t_sel ? t_up : s2_r[14];
			torq_dn_out <= t_sel ? t_dn : s2_r[13];
		end
	end

	logic signed [grb_pkg::RATE_W-1:0] rate_r;
	logic transfer_any;
	logic [2:0] tl_a;
	logic [2:0] tl_b;
	logic [2:0] tlp_a;
	logic [2:0] tlp_b;
	assign tl_a = s2_r[9:7];
	assign tl_b = s2_r[6:4];
	assign tlp_a = s3_r[9:7];
	assign tlp_b = s3_r[6:4];
	assign transfer_any = rise(tl_a[1], tlp_a[1]) | rise(tl_b[1], tlp_b[1]);

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			rate_r <= grb_pkg::RATE_RST;
		end else if (clk_en_in) begin
			// Counter restarts on transfer so each word is the rate over one interval
			if (transfer_any) begin
				rate_r <= $signed({15'h0000, n_up}) - $signed({15'h0000, n_dn});
			end else if (n_up && !n_dn) begin
				rate_r <= rate_r + 16'sh0001;
			end else if (n_dn && !n_up) begin
				rate_r <= rate_r - 16'sh0001;
			end
		end
	end

	// ****************************************
	// Rate shift register and status shifter, one pair per collector
	// ****************************************
	logic [grb_pkg::RATE_W-1:0] rsh_r [2];
	logic [grb_pkg::STATUS_W-1:0] ssh_r [2];
	logic [grb_pkg::STATUS_W-1:0] status_word;
	assign status_word = {err_bits_in, hk_in};

	for (genvar i = 0; i < 2; i++) begin : g_tlm
		logic [2:0] cur;
		logic [2:0] prv;
		assign cur = (i == 0) ? tl_a : tl_b;
		assign prv = (i == 0) ? tlp_a : tlp_b;
		always_ff @(posedge ref_clk_in) begin
			if (reset_in) begin
				rsh_r[i] <= '0;
				ssh_r[i] <= '0;
			end else if (clk_en_in) begin
				if (rise(cur[1], prv[1])) begin
					rsh_r[i] <= rate_r;
					ssh_r[i] <= status_word;
				end else if (cur[2] && rise(cur[0], prv[0])) begin
					rsh_r[i] <= {rsh_r[i][grb_pkg::RATE_W-2:0], 1'b0};
					ssh_r[i] <= {ssh_r[i][grb_pkg::STATUS_W-2:0], 1'b0};
				end
			end
		end
		always_ff @(posedge ref_clk_in) begin
			if (reset_in) begin
				rate_ser_out[i] <= 1'b0;
				status_ser_out[i] <= 1'b0;
			end else if (clk_en_in) begin
				rate_ser_out[i] <= cur[2] & rsh_r[i][grb_pkg::RATE_W-1];
				status_ser_out[i] <= cur[2] & ssh_r[i][grb_pkg::STATUS_W-1];
			end
		end
	end

	// ****************************************
	// Command receiver, decoder and bias registers
	// ****************************************
	// Decoder B sits on bit 0 of each pair and decoder A on bit 1
	logic c_dat;
	logic c_env;
	logic ck;
	logic ckp;
	assign c_dat = cmd_sel_in ? s2_r[2] : s2_r[3];
	assign c_env = cmd_sel_in ? s2_r[15] : s2_r[16];
	assign ck = cmd_sel_in ? s2_r[0] : s2_r[1];
	assign ckp = cmd_sel_in ? s3_r[0] : s3_r[1];

	logic [grb_pkg::CMD_W-1:0] cmd_sr_r;
	logic [5:0] cmd_cnt_r;
	grb_pkg::grb_cmd_s cmd;
	assign cmd = cmd_sr_r;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			cmd_sr_r <= '0;
			cmd_cnt_r <= 6'h00;
		end else if (clk_en_in) begin
			// A dropped envelope discards a partial word and frames the next one
			if (!c_env) begin
				cmd_cnt_r <= 6'h00;
			end else if (rise(ck, ckp)) begin
				cmd_sr_r <= {cmd_sr_r[grb_pkg::CMD_W-2:0], c_dat};
				cmd_cnt_r <= (cmd_cnt_r == 6'(grb_pkg::CMD_W)) ? 6'h01 : cmd_cnt_r + 6'h01;
			end
		end
	end

	logic word_done;
	assign word_done = (cmd_cnt_r == 6'(grb_pkg::CMD_W)) && !rise(ck, ckp);
	logic done_seen_r;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			done_seen_r <= 1'b0;
			cmd_done_out <= 1'b0;
			ctrl_bits_out <= grb_pkg::CTRL_RST;
			bias_out <= {3{grb_pkg::BIAS_RST}};
		end else if (clk_en_in) begin
			done_seen_r <= word_done;
			cmd_done_out <= word_done & ~done_seen_r;
			if (word_done && !done_seen_r) begin
				ctrl_bits_out <= cmd.ctrl;
				for (int k = 0; k < grb_pkg::BIAS_REGS; k++) begin
					if (cmd.bias_addr == 3'(k + 1)) begin
						bias_out[k*grb_pkg::BIAS_W +: grb_pkg::BIAS_W] <= cmd.bias_val;
					end
				end
			end
		end
	end
endmodule

// File: grb_chk.sv
/* Port checker for grb_top.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/1ps
module grb_chk (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic norm_up_in,
	input wire logic norm_dn_in,
	input wire logic test_up_in,
	input wire logic test_dn_in,
	input wire logic test_sel_in,
	input wire grb_pkg::grb_tlm_s tlm_a_in,
	input wire grb_pkg::grb_tlm_s tlm_b_in,
	input wire logic torq_up_out,
	input wire logic torq_dn_out,
	input wire logic [1:0] rate_ser_out,
	input wire logic [1:0] status_ser_out,
	input wire logic [29:0] bias_out,
	input wire logic cmd_done_out
);
	// ****
	// Properties
	// ****
	logic [2:0] run_r;
	logic up_sel;
	logic dn_sel;
	assign up_sel = test_sel_in ? test_up_in : norm_up_in;
	assign dn_sel = test_sel_in ? test_dn_in : norm_dn_in;
	always_ff @(posedge ref_clk_in) begin
		if (reset_in || !clk_en_in) run_r <= 3'h0;
		else if (run_r != 3'h7) run_r <= run_r + 3'h1;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_quiet_a; !tlm_a_in.envelope [*4]; endsequence
	sequence s_quiet_b; !tlm_b_in.envelope [*4]; endsequence
	property p_rate_a; s_quiet_a |-> !rate_ser_out[0]; endproperty
	property p_rate_b; s_quiet_b |-> !rate_ser_out[1]; endproperty
	property p_stat_a; s_quiet_a |-> !status_ser_out[0]; endproperty
	property p_stat_b; s_quiet_b |-> !status_ser_out[1]; endproperty
	property p_torq_u; run_r == 3'h7 |-> torq_up_out == $past(up_sel, 3); endproperty
	property p_torq_d; run_r == 3'h7 |-> torq_dn_out == $past(dn_sel, 3); endproperty
	property p_done; cmd_done_out |=> !cmd_done_out [*8]; endproperty
	property p_bias;
		$changed(bias_out) |-> cmd_done_out || $past(cmd_done_out) || $past(cmd_done_out, 2);
	endproperty
	a_rate_a: assert property (p_rate_a) else $error("rate A active idle");
	a_rate_b: assert property (p_rate_b) else $error("rate B active idle");
	a_stat_a: assert property (p_stat_a) else $error("status A active idle");
	a_stat_b: assert property (p_stat_b) else $error("status B active idle");
	a_torq_u: assert property (p_torq_u) else $error("torquer up wrong");
	a_torq_d: assert property (p_torq_d) else $error("torquer down wrong");
	a_done: assert property (p_done) else $error("done pulse too long");
	a_bias: assert property (p_bias) else $error("bias moved alone");
endmodule
bind grb_top grb_chk chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
	.norm_up_in(norm_up_in),
	.norm_dn_in(norm_dn_in), .test_up_in(test_up_in), .test_dn_in(test_dn_in),
	.test_sel_in(test_sel_in), .tlm_a_in(tlm_a_in), .tlm_b_in(tlm_b_in),
	.torq_up_out(torq_up_out), .torq_dn_out(torq_dn_out), .rate_ser_out(rate_ser_out),
	.status_ser_out(status_ser_out), .bias_out(bias_out), .cmd_done_out(cmd_done_out));

// File: grb_far.sv
/* Model of the two telemetry collectors and the two command decoders.
   Assumes the bench clock; all controls change on its falling edge. */
`timescale 1ns/1ps
module grb_far (
	input wire logic clk_in,
	input wire logic [1:0] rate_ser_in,
	input wire logic [1:0] stat_ser_in,
	output grb_pkg::grb_tlm_s tlm_a_out,
	output grb_pkg::grb_tlm_s tlm_b_out,
	output logic [1:0] cmd_data_out,
	output logic [1:0] cmd_clk_out,
	output logic [1:0] cmd_env_out
);
	// ****
	// Transfers
	// ****
	initial begin
		tlm_a_out = 3'h0;
		tlm_b_out = 3'h0;
		cmd_data_out = 2'h0;
		cmd_clk_out = 2'h0;
		cmd_env_out = 2'h0;
	end
	task automatic put(input int s, input logic [2:0] t, input int n);
		if (s == 1) tlm_b_out = t;
		else tlm_a_out = t;
		repeat (n) @(negedge clk_in);
	endtask
	task automatic rd(input int s, output logic [15:0] r, output logic [31:0] w);
		put(s, 3'h4, 8);
		put(s, 3'h6, 8);
		put(s, 3'h4, 8);
		for (int i = 0; i < 32; i++) begin
			if (i < 16) r = {r[14:0], rate_ser_in[s]};
			w = {w[30:0], stat_ser_in[s]};
			put(s, 3'h5, 4);
			put(s, 3'h4, 4);
		end
		put(s, 3'h0, 4);
	endtask
	task automatic cmd(input int d, input logic [31:0] c);
		for (int i = 31; i >= 0; i--) begin
			cmd_data_out[d] = c[i];
			cmd_env_out[d] = 1'h1;
			repeat (4) @(negedge clk_in);
			cmd_clk_out[d] = 1'h1;
			repeat (4) @(negedge clk_in);
			cmd_clk_out[d] = 1'h0;
		end
		cmd_data_out[d] = ~c[0];
		cmd_env_out[d] = 1'h0;
	endtask
endmodule

// File: tb_grb_top.sv
/* Self-checking bench for grb_top.
   Assumes grb_far plays both collectors and both decoders. */
`timescale 1ns/1ps
module tb_grb_top;
	// ****
	// Bench
	// ****
	logic clk = 0, rst = 1, nu = 0, nd = 0, tu = 0, td = 0, ts = 0, cs = 0, tq_u, tq_d, done;
	logic en = 1;
	logic [5:0] err = 0;
	logic [25:0] hk = 0;
	logic [1:0] rs, ss, cd, cc, ce;
	logic [18:0] ctl, cm = 0;
	logic [29:0] bias;
	logic [9:0] bm [3] = '{default: 0};
	logic [31:0] seed = 32'h0000_4ae4, w, st;
	logic [15:0] r;
	grb_pkg::grb_tlm_s ta, tb;
	int error_cnt = 0, cmp_count = 0, cnt = 0, dn = 0, u;
	always #50 clk = ~clk;
	always @(negedge clk) if (done === 1'b1) dn++;
	grb_top dut (.ref_clk_in(clk), .reset_in(rst), .clk_en_in(en), .norm_up_in(nu),
		.norm_dn_in(nd), .test_up_in(tu), .test_dn_in(td), .test_sel_in(ts), .tlm_a_in(ta),
		.tlm_b_in(tb), .cmd_sel_in(cs), .cmd_data_in(cd), .cmd_clk_in(cc), .cmd_env_in(ce),
		.err_bits_in(err), .hk_in(hk), .torq_up_out(tq_u), .torq_dn_out(tq_d),
		.rate_ser_out(rs), .status_ser_out(ss), .ctrl_bits_out(ctl), .bias_out(bias),
		.cmd_done_out(done));
	grb_far far (.clk_in(clk), .rate_ser_in(rs), .stat_ser_in(ss), .tlm_a_out(ta),
		.tlm_b_out(tb), .cmd_data_out(cd), .cmd_clk_out(cc), .cmd_env_out(ce));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		cmp_count++;
		if (a !== e) begin
			error_cnt++;
			$display("wrong value at %0t: %h expected %h", $time, a, e);
		end
	endtask
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic pl(input logic [3:0] v);
		{td, tu, nd, nu} = v;
		if (v[0] ^ v[1]) cnt += v[0] ? 1 : -1;
		repeat (4) @(negedge clk);
		chk({tq_d, tq_u}, ts ? {td, tu} : {nd, nu});
		{td, tu, nd, nu} = 4'h0;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		#2_000_000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		for (int f = 0; f < 6; f++) begin
			ts = f[0];
			repeat (20) pl(4'(rnd()));
			// Clock enable low must freeze the syncs, the counter and the torquer
			en = 1'b0;
			nu = 1'b1;
			repeat (4) @(negedge clk);
			chk({tq_d, tq_u}, 32'h0000_0000);
			nu = 1'b0;
			repeat (4) @(negedge clk);
			en = 1'b1;
			err = 6'(rnd());
			hk = 26'(rnd());
			far.rd(f % 2, r, st);
			chk({16'h0000, r}, {16'h0000, 16'(cnt)});
			chk(st, {err, hk});
			cnt = 0;
		end
		for (int k = 0; k < 10; k++) begin
			w = rnd();
			w[31:29] = 3'(k % 5);
			cs = k[0];
			u = k < 8;
			far.cmd(u ? !cs : cs, w);
			if (u) cm = w[18:0];
			if (u && w[31:29] inside {1, 2, 3}) bm[w[31:29] - 1] = w[28:19];
			repeat (8) @(negedge clk);
			chk(dn, k < 8 ? k + 1 : 8);
			chk(ctl, cm);
			chk(bias, {bm[2], bm[1], bm[0]});
		end
		results();
	end
endmodule
